// ===== rtl/gpio_out_pkg.sv
package gpio_out_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  OFS_FUNC_SEL0      = 8'h00;
  localparam logic [7:0]  OFS_FUNC_SEL0_SET  = 8'h04;
  localparam logic [7:0]  OFS_FUNC_SEL0_CLR  = 8'h08;
  localparam logic [7:0]  OFS_OUT_EN         = 8'h0C;
  localparam logic [7:0]  OFS_OUT_EN_SET     = 8'h10;
  localparam logic [7:0]  OFS_OUT_EN_CLR     = 8'h14;
  localparam logic [7:0]  OFS_OUT_LEVEL      = 8'h18;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_FUNC_SEL0      = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_EN         = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_LEVEL      = 32'h0000_0000;
  // ==========================================================
  // axi responses
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
endpackage : gpio_out_pkg

// ===== rtl/gpio_pin_driver.sv
`timescale 1ns/1ps
// per-pin output stage: drives only plain i/o pins with enable set
module gpio_pin_driver #(
  parameter int Width = 32
) (
  // register state
  input  wire logic [Width-1:0] outEnable,
  input  wire logic [Width-1:0] outLevel,
  input  wire logic [Width-1:0] altFunction,
  // pad side
  output logic      [Width-1:0] padOut,
  output logic      [Width-1:0] padOeN
);
  // ==========================================================
  // pad drive
  // level ignored when disabled or alternate function   // see [RL7]
  assign padOut = outLevel & outEnable & ~altFunction;  // see [RL6]
  // active-low enable: low while the driver is on      // see [RL2]
  assign padOeN = ~(outEnable & ~altFunction);
endmodule : gpio_pin_driver

// ===== rtl/gpio_output_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] clear alias write clears function-select ones
// [RL2] output-enable bit one turns driver on
// [RL3] enable writable directly or via aliases
// [RL4] set alias write sets enable ones
// [RL5] clear alias write clears enable ones
// [RL6] level bit zero low, one high
// [RL7] level ignored if disabled or alternate
// [RL8] software keeps absent pins at reset
// [RL9] function-select picks plain or alternate mode
// [RL10] bit n controls pin n, reset zero
module gpio_output_control #(
  parameter int Width = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // axi4-lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // axi4-lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // axi4-lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // alternate function selection from the other select bits
  input  wire logic [Width-1:0] funcSelHigh,
  // pads
  output logic [Width-1:0]      padOut,
  output logic [Width-1:0]      padOeN,
  // selection state towards the rest of the port
  output logic [Width-1:0]      funcSel0,
  output logic [Width-1:0]      altFunction
);
  // ==========================================================
  // state
  logic [Width-1:0] funcSel0_r;   // function-select bit 0
  logic [Width-1:0] outEn_r;      // output enable
  logic [Width-1:0] outLevel_r;   // output level
  logic [7:0]       awAddr_r;     // captured write address
  logic             awHave_r;     // address held
  logic [31:0]      wData_r;      // captured write data
  logic [3:0]       wStrb_r;      // captured strobes
  logic             wHave_r;      // data held
  logic             bValid_r;     // write response pending
  logic [1:0]       bResp_r;      // write response code
  logic             rValid_r;     // read data pending
  logic [31:0]      rData_r;      // read data
  logic [1:0]       rResp_r;      // read response code
  logic             doWrite;      // commit this cycle
  logic [31:0]      wMask;        // bytes enabled by strobe
  logic [31:0]      wBits;        // written ones under strobe

  // byte strobes to a bit mask
  function automatic logic [31:0] strobeMask(input logic [3:0] strb);
    strobeMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strobeMask

  // known map, registers at word-aligned offsets
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= gpio_out_pkg::OFS_OUT_LEVEL);
  endfunction : isMapped

  // ==========================================================
  // write channels: address and data accepted in any order
  assign s_axi_awready = !awHave_r && !bValid_r;
  assign s_axi_wready  = !wHave_r && !bValid_r;
  assign doWrite       = awHave_r && wHave_r && !bValid_r;
  assign wMask         = strobeMask(wStrb_r);
  assign wBits         = wData_r & wMask;

  // hold address and data until both are present
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      awHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHave_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_r <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bValid_r <= 1'b0;
      bResp_r  <= gpio_out_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r  <= isMapped(awAddr_r) ? gpio_out_pkg::RESP_OKAY : gpio_out_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp  = bResp_r;

  // ==========================================================
  // function-select bit 0, kept here for the clear alias
  // bit n is pin n, all zero after reset                     // see [RL10]
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      funcSel0_r <= gpio_out_pkg::RST_FUNC_SEL0[Width-1:0];
    end else if (doWrite) begin
      case (awAddr_r)
        gpio_out_pkg::OFS_FUNC_SEL0:
          funcSel0_r <= (funcSel0_r & ~wMask[Width-1:0]) | wBits[Width-1:0];
        gpio_out_pkg::OFS_FUNC_SEL0_SET:
          funcSel0_r <= funcSel0_r | wBits[Width-1:0];
        gpio_out_pkg::OFS_FUNC_SEL0_CLR:
          funcSel0_r <= funcSel0_r & ~wBits[Width-1:0];   // see [RL1]
        default: ;
      endcase
    end
  end

  // output enable: direct write or atomic aliases        // see [RL3]
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      outEn_r <= gpio_out_pkg::RST_OUT_EN[Width-1:0];
    end else if (doWrite) begin
      case (awAddr_r)
        gpio_out_pkg::OFS_OUT_EN:
          outEn_r <= (outEn_r & ~wMask[Width-1:0]) | wBits[Width-1:0];
        gpio_out_pkg::OFS_OUT_EN_SET:
          outEn_r <= outEn_r | wBits[Width-1:0];          // see [RL4]
        gpio_out_pkg::OFS_OUT_EN_CLR:
          outEn_r <= outEn_r & ~wBits[Width-1:0];         // see [RL5]
        default: ;
      endcase
    end
  end

  // output level, direct write only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      outLevel_r <= gpio_out_pkg::RST_OUT_LEVEL[Width-1:0];
    end else if (doWrite && awAddr_r == gpio_out_pkg::OFS_OUT_LEVEL) begin
      outLevel_r <= (outLevel_r & ~wMask[Width-1:0]) | wBits[Width-1:0];
    end
  end

  // ==========================================================
  // read channel: one cycle latency, aliases read as zero
  assign s_axi_arready = !rValid_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= gpio_out_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r  <= isMapped(s_axi_araddr) ? gpio_out_pkg::RESP_OKAY
                                         : gpio_out_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        gpio_out_pkg::OFS_FUNC_SEL0: rData_r <= 32'(funcSel0_r);
        gpio_out_pkg::OFS_OUT_EN:    rData_r <= 32'(outEn_r);
        gpio_out_pkg::OFS_OUT_LEVEL: rData_r <= 32'(outLevel_r);
        default:                     rData_r <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata  = rData_r;
  assign s_axi_rresp  = rResp_r;

  // ==========================================================
  // mode choice: any select bit set means alternate function
  assign funcSel0    = funcSel0_r;
  assign altFunction = funcSel0_r | funcSelHigh;         // see [RL9]

  gpio_pin_driver #(
    .Width       (Width)
  ) u_driver (
    .outEnable   (outEn_r),
    .outLevel    (outLevel_r),
    .altFunction (altFunction),
    .padOut      (padOut),
    .padOeN      (padOeN)
  );

  // ==========================================================
  // checks
  clear_alias_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL1]
    doWrite && awAddr_r == gpio_out_pkg::OFS_FUNC_SEL0_CLR
    |=> (funcSel0_r & $past(wBits[Width-1:0])) == '0
        && (funcSel0_r & ~$past(wBits[Width-1:0]))
           == ($past(funcSel0_r) & ~$past(wBits[Width-1:0])))
    else $error("func select clear alias wrong");
  enable_set_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL4]
    doWrite && awAddr_r == gpio_out_pkg::OFS_OUT_EN_SET
    |=> outEn_r == ($past(outEn_r) | $past(wBits[Width-1:0])))
    else $error("output enable set alias wrong");
  enable_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL5]
    doWrite && awAddr_r == gpio_out_pkg::OFS_OUT_EN_CLR
    |=> outEn_r == ($past(outEn_r) & ~$past(wBits[Width-1:0])))
    else $error("output enable clear alias wrong");
  enable_direct_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL3]
    doWrite && awAddr_r == gpio_out_pkg::OFS_OUT_EN && wStrb_r == 4'hF
    |=> 32'(outEn_r) == $past(wData_r))
    else $error("output enable direct write lost");
  driver_on_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL2]
    padOeN == ~(outEn_r & ~altFunction))
    else $error("driver enable mismatch");
  pin_level_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL6]
    (padOut & ~padOeN) == (outLevel_r & ~padOeN))
    else $error("driven level mismatch");
  level_ignored_a: assert property (@(posedge clk_sys) disable iff (reset) // see [RL7]
    (padOut & (~outEn_r | altFunction)) == '0)
    else $error("level leaks on idle pin");
  reset_zero_a: assert property (@(posedge clk_sys) // see [RL10]
    $fell(reset) |-> outEn_r == '0 && outLevel_r == '0 && funcSel0_r == '0)
    else $error("registers not zero after reset");
endmodule : gpio_output_control

// ===== verification/pin_model.sv
`timescale 1ns/1ps
// ==========================================
// external pins of the port
module pin_model (
  // clock
  input  wire logic        clk_sys,
  // pad side
  input  wire logic [31:0] padOut,
  input  wire logic [31:0] padOeN,
  // resolved pin level
  output logic      [31:0] pinLevel
);
  // no pulls: a released pin wanders every cycle, never keeps its level
  logic [31:0] floatPat_r = 32'h5555_AAAA;
  // wander pattern
  always_ff @(posedge clk_sys) begin
    floatPat_r <= ~floatPat_r;
  end
  // low enable drives the pad level, otherwise floating
  assign pinLevel = (padOut & ~padOeN) | (floatPat_r & padOeN);
endmodule : pin_model

// ===== verification/tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the output-control slice
module tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, funcSelHigh = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, padOut, padOeN, funcSel0, altFunction, pinLevel;
  logic [31:0] oeExp = 32'h0, lvlExp = 32'h0, fs0Exp = 32'h0, v;
  logic [31:0] strbMask;        // bit mask of the random byte strobes
  logic [3:0]  strb;            // random byte strobes for partial writes
  logic [34:0] expQ[$];         // {isRead, resp, data}
  int          fails = 0;
  int          total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  gpio_output_control #(.Width(32)) gpio_output_control_i (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .funcSelHigh(funcSelHigh),
    .padOut(padOut), .padOeN(padOeN), .funcSel0(funcSel0), .altFunction(altFunction));
  pin_model pin_model_i (.clk_sys(clk_sys), .padOut(padOut), .padOeN(padOeN),
    .pinLevel(pinLevel));
  // ==========================================
  // compare and verdict
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // responses are matched to the oldest note
  always @(posedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready)
      check({1'b0, s_axi_bresp, 32'h0}, expQ.size() ? expQ.pop_front() : 'x);
    if (s_axi_rvalid && s_axi_rready)
      check({1'b1, s_axi_rresp, s_axi_rdata}, expQ.size() ? expQ.pop_front() : 'x);
  end
  // ==========================================
  // bus master tasks, each ends one edge after release
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    expQ.push_back({1'b0, r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) begin
      fails++;
      finish_test;
    end
    @(posedge clk_sys);
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    expQ.push_back({1'b1, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      fails++;
      finish_test;
    end
    @(posedge clk_sys);
  endtask : axiRd
  // pins follow enable, level and selection
  task automatic chkPins;
    logic [31:0] drv;
    drv = oeExp & ~(fs0Exp | funcSelHigh);
    check({3'h0, padOeN}, {3'h0, ~drv});
    check({3'h0, padOut}, {3'h0, lvlExp & drv});
    check({3'h0, pinLevel & drv}, {3'h0, lvlExp & drv});
    check({3'h0, altFunction}, {3'h0, fs0Exp | funcSelHigh});
    check({3'h0, funcSel0}, {3'h0, fs0Exp});
  endtask : chkPins
  // ==========================================
  // main sequence; all 32 pins exist here, so no bit is held back
  initial begin
    v = $urandom(32'hE0BC8AF5);
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      axiRd(gpio_out_pkg::OFS_OUT_EN, oeExp, gpio_out_pkg::RESP_OKAY);
      axiRd(gpio_out_pkg::OFS_OUT_LEVEL, lvlExp, gpio_out_pkg::RESP_OKAY);
      axiRd(gpio_out_pkg::OFS_FUNC_SEL0, fs0Exp, gpio_out_pkg::RESP_OKAY);
      funcSelHigh <= $urandom & $urandom;
      v = (k == 4) ? 32'hFFFF_FFFF : $urandom;
      axiWr(gpio_out_pkg::OFS_OUT_EN, v, gpio_out_pkg::RESP_OKAY);
      oeExp = v;
      axiRd(gpio_out_pkg::OFS_OUT_EN, oeExp, gpio_out_pkg::RESP_OKAY);
      v = (k == 0) ? 32'h0 : $urandom;
      axiWr(gpio_out_pkg::OFS_OUT_EN_SET, v, gpio_out_pkg::RESP_OKAY);
      oeExp |= v;
      axiRd(gpio_out_pkg::OFS_OUT_EN, oeExp, gpio_out_pkg::RESP_OKAY);
      v = (k == 1) ? 32'h0 : $urandom;
      axiWr(gpio_out_pkg::OFS_OUT_EN_CLR, v, gpio_out_pkg::RESP_OKAY);
      oeExp &= ~v;
      axiRd(gpio_out_pkg::OFS_OUT_EN, oeExp, gpio_out_pkg::RESP_OKAY);
      v = $urandom;
      axiWr(gpio_out_pkg::OFS_OUT_LEVEL, v, gpio_out_pkg::RESP_OKAY);
      lvlExp = v;
      v = $urandom;
      axiWr(gpio_out_pkg::OFS_FUNC_SEL0_SET, v, gpio_out_pkg::RESP_OKAY);
      fs0Exp |= v;
      chkPins;
      // partial byte strobes on direct writes: untouched bytes keep their bits
      strb = 4'($urandom);
      strbMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      s_axi_wstrb <= strb;
      v = $urandom;
      axiWr(gpio_out_pkg::OFS_OUT_LEVEL, v, gpio_out_pkg::RESP_OKAY);
      lvlExp = (lvlExp & ~strbMask) | (v & strbMask);
      v = $urandom;
      axiWr(gpio_out_pkg::OFS_FUNC_SEL0, v, gpio_out_pkg::RESP_OKAY);
      fs0Exp = (fs0Exp & ~strbMask) | (v & strbMask);
      s_axi_wstrb <= 4'hF;
      axiRd(gpio_out_pkg::OFS_OUT_LEVEL, lvlExp, gpio_out_pkg::RESP_OKAY);
      axiRd(gpio_out_pkg::OFS_FUNC_SEL0, fs0Exp, gpio_out_pkg::RESP_OKAY);
      chkPins;
      v = (k == 2) ? 32'hFFFF_FFFF : $urandom;
      axiWr(gpio_out_pkg::OFS_FUNC_SEL0_CLR, v, gpio_out_pkg::RESP_OKAY);
      fs0Exp &= ~v;
      axiRd(gpio_out_pkg::OFS_FUNC_SEL0, fs0Exp, gpio_out_pkg::RESP_OKAY);
      axiRd(gpio_out_pkg::OFS_FUNC_SEL0_CLR, 32'h0, gpio_out_pkg::RESP_OKAY);
      // one set alias per pass, alternating between the two, reads as zero as well
      axiRd((k % 2) ? gpio_out_pkg::OFS_OUT_EN_SET : gpio_out_pkg::OFS_FUNC_SEL0_SET,
            32'h0, gpio_out_pkg::RESP_OKAY);
      chkPins;
      // unmapped place: refused, nothing changes
      // odd passes use a misaligned offset inside the map, even ones past its end
      axiWr((k % 2) ? 8'h0E : 8'h1C, 32'hFFFF_FFFF, gpio_out_pkg::RESP_SLVERR);
      axiRd((k % 2) ? 8'h0E : 8'h1C, 32'h0, gpio_out_pkg::RESP_SLVERR);
      chkPins;
      if (k == 3) begin
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        {oeExp, lvlExp, fs0Exp} = '0;
      end
      $display("test %0d done", k);
    end
    finish_test;
  end
endmodule : tb
